// ===== cdc_pkg.sv
package cdc_pkg;
  localparam int NUM_CMP = 4;
  localparam int DATA_W  = 16;
  localparam int ADDR_W  = 4;
  // register index in the plain port address space
  localparam logic [3:0] CTRL_BASE   = 4'h0;  // 0..3 control
  localparam logic [3:0] CODE_BASE   = 4'h4;  // 4..7 threshold code
  localparam logic [3:0] STAT_ADDR   = 4'h8;
  localparam logic [3:0] MASK_ADDR   = 4'h9;
  localparam logic [3:0] MODE_ADDR   = 4'hA;
  // control register field positions
  localparam int ENABLE_BIT  = 15;
  localparam int SIDL_BIT    = 13;
  localparam int INSEL_HI    = 7;
  localparam int INSEL_LO    = 6;
  localparam int EXTERNAL_REFERENCE_SELECT_BIT  = 5;
  localparam int STATE_BIT   = 3;
  localparam int INVERT_BIT  = 1;
  localparam int RANGE_BIT   = 0;
  localparam logic [15:0] CTRL_WMASK = 16'hA0E3;
  localparam logic [15:0] CODE_WMASK = 16'h03FF;
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [9:0]  CODE_RST   = 10'h000;
  localparam logic [3:0]  IRQ_RST    = 4'h0;
  // filter: pulse must persist two instruction cycles
  localparam real FILT_NS    = 20.0;
  localparam real CLK_NS     = 10.0;
  localparam int  FILT_CYC   = int'(FILT_NS / CLK_NS);
  // reference source selection towards the analog DAC
  localparam logic [1:0] REF_BANDGAP = 2'h0;
  localparam logic [1:0] REF_HALFAVDD = 2'h1;
  localparam logic [1:0] REF_EXTERNAL = 2'h2;

  typedef struct packed {
    logic       enable;
    logic       refOn;
    logic [1:0] refSel;
    logic [9:0] code;
    logic [1:0] inputSelect;
  } cdc_analog_t;

  typedef enum logic [1:0] {
    CDC_RUN   = 2'b00,
    CDC_IDLE  = 2'b01,
    CDC_SLEEP = 2'b10
  } cdc_mode_t;
endpackage

// ===== cdc_top.sv
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - A comparator's enable bit low turns off that comparator and its DAC.
// - Stop-in-idle set halts comparators in Idle, all four clear lets them run on.
// - Stop-in-idle bits are ORed so any one stops all comparators in Idle.
// - Input select codes 0..3 route pin a, b, c, d to the positive input.
// - External reference bit chooses the external pin or an internal source.
// - With internal source, range 0 picks bandgap and 1 picks half supply.
// - Invert bit one inverts the comparator output, zero passes it.
// - The status bit reads the filtered polarity-adjusted output.
// - The 10-bit code sets the threshold as code times reference over 1024.
// - Code register bits 15 to 10 read zero and ignore writes.
// - While enabled the selected pin has its digital input buffer off.
// - In run the output is filtered so pulses under two cycles vanish.
// - In Sleep, or Idle with no stop-in-idle bit set, the filter is bypassed by a registered wake from the synchronised output.
// - Unimplemented bits of control and code registers read zero.
module cdc_top (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic [3:0]               regAddr,
  input  wire logic [15:0]              regWdata,
  input  wire logic                     regWrite,
  input  wire logic                     regRead,
  output logic [15:0]                   regRdata,
  input  wire logic                     idleMode,
  input  wire logic                     sleepMode,
  input  wire logic [3:0]               cmpRaw,
  output cdc_pkg::cdc_analog_t          analogCtrl [4],
  output logic [15:0]                   pinBufDisable,
  output logic [3:0]                    cmpEvent,
  output logic [3:0]                    wakeRaw,
  output logic                          irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] ctrl_reg [4];
  logic [9:0]  code_reg [4];
  logic [3:0]  stat_reg;
  logic [3:0]  mask_reg;
  logic [3:0]  sync1_reg;
  logic [3:0]  sync2_reg;
  logic [3:0]  filt_reg;
  logic [3:0]  prevFilt_reg;
  logic [1:0]  mode_reg;
  logic        anyStopIdle;
  logic        runActive;
  logic        lowPower;
  logic [3:0]  polarized;
  logic [3:0]  rising;
  logic [15:0] rdNext;

  always_ff @(posedge clock) begin
    if (rst) begin
      mode_reg <= 2'h0;
    end else begin
      mode_reg <= {sleepMode, idleMode};
    end
  end

  always_comb begin
    anyStopIdle = 1'b0;
    for (int i = 0; i < 4; i++) begin
      anyStopIdle = anyStopIdle | ctrl_reg[i][cdc_pkg::SIDL_BIT];
    end
  end

  // module enable lives in every control word; each comparator has its own
  assign lowPower  = mode_reg != 2'h0;
  ////////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        ctrl_reg[i] <= cdc_pkg::CTRL_RST;
        code_reg[i] <= cdc_pkg::CODE_RST;
      end
    end else if (regWrite) begin
      for (int i = 0; i < 4; i++) begin
        if (regAddr == cdc_pkg::CTRL_BASE + 4'(i)) begin
          ctrl_reg[i] <= regWdata & cdc_pkg::CTRL_WMASK;
        end
        if (regAddr == cdc_pkg::CODE_BASE + 4'(i)) begin
          code_reg[i] <= regWdata[9:0];
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mask_reg <= cdc_pkg::IRQ_RST;
    end else if (regWrite && regAddr == cdc_pkg::MASK_ADDR) begin
      mask_reg <= regWdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparator path: the raw analog outputs are async to the clock
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      // only the second synchroniser stage may feed logic
      polarized[i] = sync2_reg[i]
                     ^ ctrl_reg[i][cdc_pkg::INVERT_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= cmpRaw;
      sync2_reg <= sync1_reg;
    end
  end

  // filter: output follows only after the input held for two samples
  logic [3:0] hold_reg;
  always_ff @(posedge clock) begin
    if (rst) begin
      hold_reg <= 4'h0;
      filt_reg <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        hold_reg[i] <= polarized[i];
        if (!runActive || !ctrl_reg[i][cdc_pkg::ENABLE_BIT]) begin
          filt_reg[i] <= 1'b0;
        end else if (polarized[i] == hold_reg[i]) begin
          filt_reg[i] <= polarized[i];
        end
      end
    end
  end

  // operation stops in Idle only when some stop-in-idle bit is set
  assign runActive = !mode_reg[1] && !(mode_reg[0] && anyStopIdle);

  always_ff @(posedge clock) begin
    if (rst) begin
      prevFilt_reg <= 4'h0;
    end else begin
      prevFilt_reg <= filt_reg;
    end
  end
  assign rising = filt_reg & ~prevFilt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // sticky status, write one to clear, set wins
  always_ff @(posedge clock) begin
    if (rst) begin
      stat_reg <= cdc_pkg::IRQ_RST;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (rising[i]) begin
          stat_reg[i] <= 1'b1;
        end else if (regWrite && regAddr == cdc_pkg::STAT_ADDR
                     && regWdata[i]) begin
          stat_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq      <= 1'b0;
      cmpEvent <= 4'h0;
    end else begin
      irq      <= |(stat_reg & mask_reg);
      cmpEvent <= rising;
    end
  end

  // wake path: the low-power state blocks the clock, so this is only
  // registered while the clock still runs; real wake uses the analog path
  always_ff @(posedge clock) begin
    if (rst) begin
      wakeRaw <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        wakeRaw[i] <= lowPower && ctrl_reg[i][cdc_pkg::ENABLE_BIT]
                      && !(mode_reg[0] && anyStopIdle) ?
                      polarized[i] : 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog side controls
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        analogCtrl[i] <= '0;
      end
      pinBufDisable <= 16'h0000;
    end else begin
      for (int i = 0; i < 4; i++) begin
        analogCtrl[i].enable <= ctrl_reg[i][cdc_pkg::ENABLE_BIT]
                                && runActive;
        analogCtrl[i].refOn  <= ctrl_reg[i][cdc_pkg::ENABLE_BIT]
                                && runActive;
        if (ctrl_reg[i][cdc_pkg::EXTERNAL_REFERENCE_SELECT_BIT]) begin
          analogCtrl[i].refSel <= cdc_pkg::REF_EXTERNAL;
        end else if (ctrl_reg[i][cdc_pkg::RANGE_BIT]) begin
          analogCtrl[i].refSel <= cdc_pkg::REF_HALFAVDD;
        end else begin
          analogCtrl[i].refSel <= cdc_pkg::REF_BANDGAP;
        end
        analogCtrl[i].code   <= code_reg[i];
        analogCtrl[i].inputSelect <=
          ctrl_reg[i][cdc_pkg::INSEL_HI:cdc_pkg::INSEL_LO];
        for (int p = 0; p < 4; p++) begin
          pinBufDisable[i*4+p] <= ctrl_reg[i][cdc_pkg::ENABLE_BIT]
            && (ctrl_reg[i][cdc_pkg::INSEL_HI:cdc_pkg::INSEL_LO]
                == 2'(p));
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reads: data one cycle after the strobe
  always_comb begin
    rdNext = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      if (regAddr == cdc_pkg::CTRL_BASE + 4'(i)) begin
        rdNext = ctrl_reg[i];
        rdNext[cdc_pkg::STATE_BIT] = filt_reg[i];
      end
      if (regAddr == cdc_pkg::CODE_BASE + 4'(i)) begin
        rdNext = {6'h00, code_reg[i]};
      end
    end
    if (regAddr == cdc_pkg::STAT_ADDR) begin
      rdNext = {12'h000, stat_reg};
    end
    if (regAddr == cdc_pkg::MASK_ADDR) begin
      rdNext = {12'h000, mask_reg};
    end
    if (regAddr == cdc_pkg::MODE_ADDR) begin
      rdNext = {14'h0000, mode_reg};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      regRdata <= 16'h0000;
    end else if (regRead) begin
      regRdata <= rdNext;
    end else begin
      regRdata <= 16'h0000;
    end
  end
endmodule

// ===== cdc_pins_model.sv
`timescale 1ns/1ns
module cdc_pins_model (
  input  wire logic [15:0]     pins,
  input  cdc_pkg::cdc_analog_t analogCtrl [4],
  output logic [3:0]           cmpRaw
);
  // a pin level stands for its comparison against the threshold
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      cmpRaw[i] = pins[i * 4 + analogCtrl[i].inputSelect];
    end
  end
endmodule

// ===== cdc_top_chk.sv
`timescale 1ns/1ns
module cdc_top_chk (
  input wire logic            clock,
  input wire logic            rst,
  input wire logic [3:0]      regAddr,
  input wire logic [15:0]     regWdata,
  input wire logic            regWrite,
  input wire logic            regRead,
  input wire logic [15:0]     regRdata,
  input wire logic            idleMode,
  input wire logic            sleepMode,
  input wire logic [3:0]      cmpRaw,
  input cdc_pkg::cdc_analog_t analogCtrl [4],
  input wire logic [15:0]     pinBufDisable,
  input wire logic [3:0]      cmpEvent,
  input wire logic [3:0]      wakeRaw,
  input wire logic            irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_codeRsv;
    $past(regRead && regAddr[3:2] == 2'h1) |-> regRdata[15:10] == 6'h00;
  endproperty
  a_codeRsv: assert property (p_codeRsv) else $error("code bits set");
  property p_ctrlRsv;
    $past(regRead && regAddr[3:2] == 2'h0) |-> (regRdata & 16'h5F14) == 0;
  endproperty
  a_ctrlRsv: assert property (p_ctrlRsv) else $error("ctrl bits set");
  property p_codeAn;
    (regWrite && regAddr == 4'h4) ##1 !regWrite [*2]
      |-> analogCtrl[0].code == $past(regWdata[9:0], 2);
  endproperty
  a_codeAn: assert property (p_codeAn) else $error("code not applied");
  property p_bufHot;
    pinBufDisable[3:0] != 4'h0
      |-> pinBufDisable[3:0] == 4'h1 << analogCtrl[0].inputSelect;
  endproperty
  a_bufHot: assert property (p_bufHot) else $error("wrong buffer off");
  property p_evPulse;
    cmpEvent[0] |=> !cmpEvent[0];
  endproperty
  a_evPulse: assert property (p_evPulse) else $error("event too long");
  property p_glitch;
    !cmpRaw[0] [*8] ##1 cmpRaw[0] ##1 !cmpRaw[0] |=> !cmpEvent[0] [*6];
  endproperty
  a_glitch: assert property (p_glitch) else $error("glitch passed");
  property p_wakeRun;
    (!idleMode && !sleepMode) [*3] |-> wakeRaw == 4'h0;
  endproperty
  a_wakeRun: assert property (p_wakeRun) else $error("wake in run");
  property p_off;
    !analogCtrl[0].enable [*6] |-> !cmpEvent[0];
  endproperty
  a_off: assert property (p_off) else $error("event while off");
endmodule
bind cdc_top cdc_top_chk cdc_top_chk_inst (.clock(clock), .rst(rst),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
  .regRead(regRead), .regRdata(regRdata), .idleMode(idleMode),
  .sleepMode(sleepMode), .cmpRaw(cmpRaw), .analogCtrl(analogCtrl),
  .pinBufDisable(pinBufDisable), .cmpEvent(cmpEvent), .wakeRaw(wakeRaw),
  .irq(irq));

// ===== cdc_top_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, v) begin num_checks++; if ((v) !== (e)) begin \
  num_errors++; $display("CHECK FAILED %s exp %h got %h", n, e, v); end end
module cdc_top_tb;
  logic                 clock = 1'b0;
  logic                 rst = 1'b1;
  logic [3:0]           regAddr = 4'h0;
  logic [15:0]          regWdata = 16'h0000;
  logic                 regWrite = 1'b0;
  logic                 regRead = 1'b0;
  logic                 idleMode = 1'b0;
  logic                 sleepMode = 1'b0;
  logic [15:0]          pins = 16'h0000;
  logic [15:0]          regRdata, pinBufDisable, d;
  logic [3:0]           cmpRaw, cmpEvent, wakeRaw;
  logic                 irq;
  cdc_pkg::cdc_analog_t analogCtrl [4];
  int                   num_errors = 0, num_checks = 0, cyc = 0;
  cdc_top cdc_top_inst (.clock(clock), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .idleMode(idleMode), .sleepMode(sleepMode),
    .cmpRaw(cmpRaw), .analogCtrl(analogCtrl),
    .pinBufDisable(pinBufDisable), .cmpEvent(cmpEvent),
    .wakeRaw(wakeRaw), .irq(irq));
  cdc_pins_model cdc_pins_model_inst (.pins(pins),
    .analogCtrl(analogCtrl), .cmpRaw(cmpRaw));
  always #5 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////
  task w(input int n);
    repeat (n) @(posedge clock);
  endtask
  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    // data stand for the whole cycle after the strobe; sample mid-cycle
    @(negedge clock);
    v = regRdata;
    @(posedge clock);
  endtask
  task finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // hang guard well above the roughly two hundred cycles the sequence needs
  always @(posedge clock) begin
    cyc++;
    if (cyc > 5000) begin
      num_errors++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    w(4);
    rst <= 1'b0;
    rd(4'h0, d); `CHK("ctrl rst", 16'h0000, d)
    wr(4'h4, 16'hFFFF);
    rd(4'h4, d); `CHK("code rd", 16'h03FF, d)
    `CHK("code max", 10'h3FF, analogCtrl[0].code)
    wr(4'h4, 16'h0000);
    w(2); `CHK("code", 10'h000, analogCtrl[0].code)
    for (int s = 0; s < 4; s++) begin
      wr(4'h0, 16'h8000 | (s << 6));
      pins <= 16'h0001 << s;
      w(8); `CHK("sel", 2'(s), analogCtrl[0].inputSelect)
      `CHK("buf", 4'h1 << s, pinBufDisable[3:0])
      rd(4'h0, d); `CHK("state", 1'b1, d[3])
    end
    for (int m = 0; m < 4; m++) begin
      wr(4'h0, 16'h8000 | (m[1] << 5) | m[0]);
      w(2); `CHK("ref", m[1] ? 2'h2 : 2'(m[0]), analogCtrl[0].refSel)
      `CHK("on", 1'b1, analogCtrl[0].enable)
    end
    pins <= 16'h0001;
    wr(4'h0, 16'h8002);
    w(8);
    rd(4'h0, d); `CHK("invert", 1'b0, d[3])
    pins <= 16'h0000;
    wr(4'h0, 16'h8000);
    wr(4'h9, 16'h0001);
    wr(4'h8, 16'h000F);
    w(8); `CHK("irq idle", 1'b0, irq)
    pins <= 16'h0001;
    w(8); `CHK("irq", 1'b1, irq)
    rd(4'h8, d); `CHK("stat", 1'b1, d[0])
    wr(4'h8, 16'h0001);
    w(3); `CHK("irq clr", 1'b0, irq)
    pins <= 16'h0000;
    w(10);
    pins <= 16'h0001;
    @(posedge clock);
    pins <= 16'h0000;
    w(8);
    rd(4'h8, d); `CHK("glitch", 1'b0, d[0])
    pins <= 16'h0010;
    wr(4'h0, 16'hA000);
    wr(4'h1, 16'h8000);
    idleMode <= 1'b1;
    w(8);
    rd(4'h1, d); `CHK("idle stop", 1'b0, d[3])
    wr(4'h0, 16'h8000);
    w(8);
    rd(4'h1, d); `CHK("idle run", 1'b1, d[3])
    idleMode <= 1'b0;
    wr(4'h0, 16'h0000);
    w(3); `CHK("off", 1'b0, analogCtrl[0].enable)
    `CHK("buf off", 4'h0, pinBufDisable[3:0])
    sleepMode <= 1'b1;
    w(6); `CHK("wake", 1'b1, wakeRaw[1])
    sleepMode <= 1'b0;
    rd(4'hF, d); `CHK("unmapped", 16'h0000, d)
    finish_test();
  end
endmodule
